// ==== rtl/lsd_control.sv ====
// file: register bank and protection logic of the two low-side relay drivers
//
// Contract
// - drivers off outside Normal mode
// - control 0x30, status 0x31, key 0x32
// - decode at blocking and non-blocking bases
// - control bit 7 gates overtemp interrupt
// - control bits 5,4 select PWM channel
// - control bits 3,2 enable modulation
// - on bits act only after key written
// - status bit 7 overtemp; drivers held off
// - status read clears overtemp interrupt flag
// - status bits 3,2 report current limitation
// - status bits 1,0 report open load
// - no open load while driver off
// - only key 0x5 unlocks driver control
// - overvoltage clears on bits and unlock
// - control write re-enables after overtemp gone
`timescale 1ns/10ps
module lsd_control
  import lsd_pkg::*;
#(
  parameter int ADDR_W = LSD_ADDR_W,
  parameter int DRIVERS = 2
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  // die-to-die register port
  input wire logic [ADDR_W-1:0] i_bus_addr,
  input wire logic i_bus_wr,
  input wire logic i_bus_rd,
  input wire logic [LSD_DATA_W-1:0] i_bus_wdata,
  output logic [LSD_DATA_W-1:0] o_bus_rdata,
  output logic o_bus_ack,
  // device mode and analog conditions
  input wire logic i_normal_mode,
  input wire logic i_overtemp,
  input wire logic i_regulator_overvoltage,
  input wire logic [DRIVERS-1:0] i_current_limited,
  input wire logic [DRIVERS-1:0] i_open_load,
  // modulation channels
  input wire logic [1:0] i_pwm,
  // driver outputs and interrupt request
  output logic [DRIVERS-1:0] o_driver_on,
  output logic o_overtemp_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0] control;
    logic [3:0] key;
    logic unlocked;
    logic ot_shutdown;
    logic ot_flag;
    logic ot_prev;
    logic [DRIVERS-1:0] drive;
    logic [7:0] rdata;
    logic ack;
    logic irq;
  } lsd_state_s;

  lsd_state_s state_reg;
  lsd_state_s state_next;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  logic [ADDR_W-1:0] rel_blocking;
  logic [ADDR_W-1:0] rel_nonblocking;
  logic [ADDR_W-1:0] rel_addr;
  logic hit_control;
  logic hit_status;
  logic hit_key;

  always_comb begin
    rel_blocking = i_bus_addr - ADDR_W'(LSD_BASE_BLOCKING);
    rel_nonblocking = i_bus_addr - ADDR_W'(LSD_BASE_NONBLOCKING);
    if (i_bus_addr >= ADDR_W'(LSD_BASE_NONBLOCKING)) begin
      rel_addr = rel_nonblocking;
    end else if (i_bus_addr >= ADDR_W'(LSD_BASE_BLOCKING)) begin
      rel_addr = rel_blocking;
    end else begin
      rel_addr = '1;
    end
    hit_control = (rel_addr == ADDR_W'(LSD_OFF_CONTROL));
    hit_status = (rel_addr == ADDR_W'(LSD_OFF_STATUS));
    hit_key = (rel_addr == ADDR_W'(LSD_OFF_UNLOCK_KEY));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // driver gating

  logic allow;
  logic [DRIVERS-1:0] drive_comb;
  logic [7:0] status_value;
  logic [DRIVERS-1:0] open_load_seen;

  // overtemp blocks directly as well as via the latch, so the first hot cycle is covered
  assign allow = i_normal_mode & state_reg.unlocked & ~state_reg.ot_shutdown
    & ~i_overtemp;

  genvar gi;
  generate
    for (gi = 0; gi < DRIVERS; gi++) begin : g_drv
      lsd_driver_gate #(
        .CHANNELS(2)
      ) u_gate (
        .i_on(state_reg.control[LSD_CTL_DRIVER_ONE_ON + gi]),
        .i_mod_enable(state_reg.control[LSD_CTL_DRIVER_ONE_MODULATION_ENABLE + gi]),
        .i_channel_select(state_reg.control[LSD_CTL_DRIVER_ONE_CHANNEL_SELECT + gi]),
        .i_pwm(i_pwm),
        .i_allow(allow),
        .o_drive(drive_comb[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // status value

  // open load only counts while the driver is actually conducting
  assign open_load_seen = i_open_load & state_reg.drive;

  always_comb begin
    status_value = 8'h00;
    status_value[LSD_STS_OVERTEMP_PRESENT] = i_overtemp;
    status_value[LSD_STS_DRIVER_TWO_CURRENT_LIMITED] = i_current_limited[1];
    status_value[LSD_STS_DRIVER_ONE_CURRENT_LIMITED] = i_current_limited[0];
    status_value[LSD_STS_DRIVER_TWO_OPEN_LOAD] = open_load_seen[1];
    status_value[LSD_STS_DRIVER_ONE_OPEN_LOAD] = open_load_seen[0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  logic wr_control;
  logic wr_key;
  logic rd_status;
  logic ot_rise;

  always_comb begin
    wr_control = i_bus_wr & hit_control;
    wr_key = i_bus_wr & hit_key;
    rd_status = i_bus_rd & hit_status;
    ot_rise = i_overtemp & ~state_reg.ot_prev;
    state_next = state_reg;

    // control register
    if (wr_control) begin
      state_next.control = i_bus_wdata & LSD_CTL_WRITE_MASK;
    end
    if (i_regulator_overvoltage) begin
      state_next.control = state_next.control & ~LSD_CTL_ON_MASK;
    end

    // unlock key: any value other than the key relocks
    if (wr_key) begin
      state_next.key = i_bus_wdata[LSD_KEY_W-1:0];
      state_next.unlocked = (i_bus_wdata[LSD_KEY_W-1:0] == LSD_KEY_VALUE);
    end
    if (i_regulator_overvoltage) begin
      state_next.unlocked = 1'b0;
    end

    // overtemp shutdown latch, released only by a control write once cool
    if (wr_control && !i_overtemp) begin
      state_next.ot_shutdown = 1'b0;
    end
    if (i_overtemp) begin
      state_next.ot_shutdown = 1'b1;
    end

    // pending overtemp flag: a new event beats a simultaneous read
    state_next.ot_prev = i_overtemp;
    if (rd_status) begin
      state_next.ot_flag = 1'b0;
    end
    if (ot_rise) begin
      state_next.ot_flag = 1'b1;
    end
    state_next.irq = state_next.ot_flag
      & state_next.control[LSD_CTL_OVERTEMP_IRQ_ENABLE];

    // drive outputs
    state_next.drive = drive_comb;

    // read path, unmapped reads answer zero
    state_next.ack = i_bus_rd | i_bus_wr;
    if (i_bus_rd) begin
      if (hit_control) begin
        state_next.rdata = state_reg.control;
      end else if (hit_status) begin
        state_next.rdata = status_value;
      end else if (hit_key) begin
        state_next.rdata = {4'h0, state_reg.key};
      end else begin
        state_next.rdata = LSD_RDATA_RESET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg.control <= LSD_CONTROL_RESET;
      state_reg.key <= LSD_KEY_RESET;
      state_reg.unlocked <= 1'b0;
      state_reg.ot_shutdown <= 1'b0;
      state_reg.ot_flag <= 1'b0;
      state_reg.ot_prev <= 1'b0;
      state_reg.drive <= '0;
      state_reg.rdata <= LSD_RDATA_RESET;
      state_reg.ack <= 1'b0;
      state_reg.irq <= 1'b0;
    end else if (i_clk_en) begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_driver_on = state_reg.drive;
  assign o_overtemp_irq = state_reg.irq;
  assign o_bus_rdata = state_reg.rdata;
  assign o_bus_ack = state_reg.ack;

endmodule

// ==== rtl/lsd_pkg.sv ====
// package: register map, field layout and constants of the low-side driver control block
package lsd_pkg;

  // bus geometry
  localparam int LSD_ADDR_W = 10;
  localparam int LSD_DATA_W = 8;

  // base addresses of the two access windows
  localparam logic [9:0] LSD_BASE_BLOCKING = 10'h200;
  localparam logic [9:0] LSD_BASE_NONBLOCKING = 10'h300;

  // register offsets
  localparam logic [9:0] LSD_OFF_CONTROL = 10'h030;
  localparam logic [9:0] LSD_OFF_STATUS = 10'h031;
  localparam logic [9:0] LSD_OFF_UNLOCK_KEY = 10'h032;

  // control register fields
  localparam int LSD_CTL_OVERTEMP_IRQ_ENABLE = 7;
  localparam int LSD_CTL_DRIVER_TWO_CHANNEL_SELECT = 5;
  localparam int LSD_CTL_DRIVER_ONE_CHANNEL_SELECT = 4;
  localparam int LSD_CTL_DRIVER_TWO_MODULATION_ENABLE = 3;
  localparam int LSD_CTL_DRIVER_ONE_MODULATION_ENABLE = 2;
  localparam int LSD_CTL_DRIVER_TWO_ON = 1;
  localparam int LSD_CTL_DRIVER_ONE_ON = 0;
  localparam logic [7:0] LSD_CTL_WRITE_MASK = 8'hBF;
  localparam logic [7:0] LSD_CTL_ON_MASK = 8'h03;

  // status register fields
  localparam int LSD_STS_OVERTEMP_PRESENT = 7;
  localparam int LSD_STS_DRIVER_TWO_CURRENT_LIMITED = 3;
  localparam int LSD_STS_DRIVER_ONE_CURRENT_LIMITED = 2;
  localparam int LSD_STS_DRIVER_TWO_OPEN_LOAD = 1;
  localparam int LSD_STS_DRIVER_ONE_OPEN_LOAD = 0;

  // unlock key field
  localparam int LSD_KEY_W = 4;
  localparam logic [3:0] LSD_KEY_VALUE = 4'h5;

  // reset values
  localparam logic [7:0] LSD_CONTROL_RESET = 8'h00;
  localparam logic [3:0] LSD_KEY_RESET = 4'h0;
  localparam logic [7:0] LSD_RDATA_RESET = 8'h00;

endpackage

// ==== rtl/lsd_driver_gate.sv ====
// file: gating of one low-side driver from its control bits and the modulation channels
`timescale 1ns/10ps
module lsd_driver_gate #(
  parameter int CHANNELS = 2
) (
  // control bits of this driver
  input wire logic i_on,
  input wire logic i_mod_enable,
  input wire logic i_channel_select,
  // modulation channels and global permission
  input wire logic [CHANNELS-1:0] i_pwm,
  input wire logic i_allow,
  // resulting drive level
  output logic o_drive
);

  logic modulation;

  always_comb begin
    modulation = i_mod_enable ? i_pwm[i_channel_select] : 1'b1;
    o_drive = i_allow & i_on & modulation;
  end

endmodule

// ==== bench/lsd_control_asserts.sv ====
// checker: port-level properties of the low-side driver control block
`timescale 1ns/10ps
module lsd_control_asserts
  import lsd_pkg::*;
#(
  parameter int ADDR_W = LSD_ADDR_W,
  parameter int DRIVERS = 2
) (
  // watched ports
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic [ADDR_W-1:0] i_bus_addr,
  input wire logic i_bus_wr,
  input wire logic i_bus_rd,
  input wire logic [LSD_DATA_W-1:0] i_bus_wdata,
  input wire logic [LSD_DATA_W-1:0] o_bus_rdata,
  input wire logic o_bus_ack,
  input wire logic i_normal_mode,
  input wire logic i_overtemp,
  input wire logic i_regulator_overvoltage,
  input wire logic [DRIVERS-1:0] i_current_limited,
  input wire logic [DRIVERS-1:0] i_open_load,
  input wire logic [1:0] i_pwm,
  input wire logic [DRIVERS-1:0] o_driver_on,
  input wire logic o_overtemp_irq
);
  logic rd_sts;
  assign rd_sts = i_clk_en && i_bus_rd && (i_bus_addr == 10'h231 || i_bus_addr == 10'h331);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  //////////////////////////////////////////////////
  a_ack_follows_req: assert property ((i_clk_en && (i_bus_wr || i_bus_rd)) |=> o_bus_ack)
    else $error("ack missing");
  a_sleep_forces_off: assert property ((i_clk_en && !i_normal_mode) |=> o_driver_on == '0)
    else $error("driver on outside normal mode");
  a_overtemp_forces_off: assert property ((i_clk_en && i_overtemp) |=> o_driver_on == '0)
    else $error("driver on during overtemp");
  a_read_clears_irq: assert property ((rd_sts && !i_overtemp && !$past(i_overtemp))
    |=> !o_overtemp_irq) else $error("irq survives status read");
  a_status_upper_bits: assert property (rd_sts |=> o_bus_rdata[7:2] ==
    {$past(i_overtemp), 3'h0, $past(i_current_limited)}) else $error("status bits wrong");
  a_open_load_gated: assert property (rd_sts |=>
    o_bus_rdata[1:0] == $past(i_open_load & o_driver_on)) else $error("open load wrong");
  a_unmapped_reads_zero: assert property ((i_clk_en && i_bus_rd && i_bus_addr == 10'h233)
    |=> o_bus_rdata == 8'h00) else $error("unmapped read not zero");
  a_overvoltage_off: assert property ((i_clk_en && i_regulator_overvoltage) [*2]
    |=> o_driver_on == '0) else $error("driver on after overvoltage");
  c_irq_read: cover property (rd_sts && o_overtemp_irq);
  c_both_on: cover property (&o_driver_on);
  c_open_load: cover property (rd_sts && |(i_open_load & o_driver_on));
endmodule
bind lsd_control lsd_control_asserts #(.ADDR_W(ADDR_W), .DRIVERS(DRIVERS))
  lsd_control_asserts_inst (.i_clk, .i_arst_n, .i_clk_en, .i_bus_addr, .i_bus_wr, .i_bus_rd,
  .i_bus_wdata, .o_bus_rdata, .o_bus_ack, .i_normal_mode, .i_overtemp, .i_regulator_overvoltage,
  .i_current_limited, .i_open_load, .i_pwm, .o_driver_on, .o_overtemp_irq);

// ==== bench/tb.sv ====
// testbench: register access, unlock, modulation, protection and status of the low-side block
`timescale 1ns/10ps
module tb;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_clk_en = 1'b1, i_bus_wr = 1'b0, i_bus_rd = 1'b0;
  logic i_normal_mode = 1'b1, i_overtemp = 1'b0, i_regulator_overvoltage = 1'b0;
  logic [9:0] i_bus_addr = 10'h000;
  logic [7:0] i_bus_wdata = 8'h00, q, o_bus_rdata;
  logic [1:0] i_current_limited = 2'h0, i_open_load = 2'h0, i_pwm = 2'h0, o_driver_on;
  logic o_bus_ack, o_overtemp_irq;
  int n_fail = 0, n_tests = 0, cyc = 0;
  lsd_control lsd_control_inst (.i_clk, .i_arst_n, .i_clk_en, .i_bus_addr, .i_bus_wr, .i_bus_rd,
    .i_bus_wdata, .o_bus_rdata, .o_bus_ack, .i_normal_mode, .i_overtemp,
    .i_regulator_overvoltage, .i_current_limited, .i_open_load, .i_pwm, .o_driver_on,
    .o_overtemp_irq);
  always #2 i_clk = ~i_clk;
  // whole run needs about a hundred cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      finish_test();
    end
  end
  //////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // strobe stays one cycle; ack and read data are looked at one cycle later
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_bus_wr = w;
    i_bus_rd = !w;
    i_bus_addr = a;
    i_bus_wdata = d;
    @(negedge i_clk);
    i_bus_wr = 1'b0;
    i_bus_rd = 1'b0;
    q = o_bus_rdata;
    chk("ack", 8'h01, {7'h0, o_bus_ack});
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk("rdata", e, q);
  endtask
  task automatic drv(input logic [1:0] e);
    repeat (2) @(negedge i_clk);
    chk("drive", {6'h0, e}, {6'h0, o_driver_on});
  endtask
  task automatic irq(input logic e);
    chk("irq", {7'h0, e}, {7'h0, o_overtemp_irq});
  endtask
  //////////////////////////////////////////////////
  task automatic t_lock;
    rd(10'h230, 8'h00);
    acc(1'b1, 10'h230, 8'h03);
    drv(2'h0);
    acc(1'b1, 10'h232, 8'h03);
    drv(2'h0);
    acc(1'b1, 10'h332, 8'hF5);
    rd(10'h332, 8'h05);
    acc(1'b1, 10'h330, 8'hFF);
    rd(10'h230, 8'hBF);
    drv(2'h0);
    acc(1'b1, 10'h231, 8'hFF);
    rd(10'h231, 8'h00);
    rd(10'h233, 8'h00);
  endtask
  task automatic t_pwm;
    acc(1'b1, 10'h230, 8'h1F);
    i_pwm = 2'h2;
    drv(2'h1);
    i_pwm = 2'h1;
    drv(2'h2);
    acc(1'b1, 10'h230, 8'h2F);
    drv(2'h1);
  endtask
  task automatic t_status;
    acc(1'b1, 10'h230, 8'h01);
    i_open_load = 2'h3;
    i_current_limited = 2'h2;
    drv(2'h1);
    rd(10'h231, 8'h09);
    i_open_load = 2'h0;
    i_current_limited = 2'h0;
  endtask
  task automatic t_otemp;
    acc(1'b1, 10'h230, 8'h03);
    i_overtemp = 1'b1;
    drv(2'h0);
    irq(1'b0);
    rd(10'h231, 8'h80);
    i_overtemp = 1'b0;
    drv(2'h0);
    acc(1'b1, 10'h230, 8'h83);
    drv(2'h3);
    irq(1'b0);
    i_overtemp = 1'b1;
    drv(2'h0);
    irq(1'b1);
    rd(10'h231, 8'h80);
    irq(1'b0);
    i_overtemp = 1'b0;
    acc(1'b1, 10'h230, 8'h03);
    i_normal_mode = 1'b0;
    drv(2'h0);
    i_normal_mode = 1'b1;
    drv(2'h3);
  endtask
  task automatic t_ovv;
    i_regulator_overvoltage = 1'b1;
    drv(2'h0);
    i_regulator_overvoltage = 1'b0;
    rd(10'h230, 8'h00);
    acc(1'b1, 10'h230, 8'h03);
    drv(2'h0);
    acc(1'b1, 10'h232, 8'h05);
    acc(1'b1, 10'h230, 8'h03);
    drv(2'h3);
  endtask
  // clock enable low must freeze every register, bus strobes included
  task automatic t_freeze;
    @(negedge i_clk);
    i_clk_en = 1'b0;
    i_bus_wr = 1'b1;
    i_bus_addr = 10'h230;
    i_bus_wdata = 8'h00;
    i_normal_mode = 1'b0;
    @(negedge i_clk);
    chk("frozen ack", 8'h00, {7'h0, o_bus_ack});
    chk("frozen drive", 8'h03, {6'h0, o_driver_on});
    i_bus_wr = 1'b0;
    i_normal_mode = 1'b1;
    i_clk_en = 1'b1;
    drv(2'h3);
    rd(10'h230, 8'h03);
  endtask
  // reset in mid-run must relock and clear everything
  task automatic t_rerun;
    @(negedge i_clk);
    i_arst_n = 1'b0;
    @(negedge i_clk);
    chk("reset drive", 8'h00, {6'h0, o_driver_on});
    i_arst_n = 1'b1;
    drv(2'h0);
    rd(10'h230, 8'h00);
    rd(10'h232, 8'h00);
    acc(1'b1, 10'h230, 8'h03);
    drv(2'h0);
  endtask
  task automatic finish_test();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge i_clk);
    i_arst_n = 1'b1;
    t_lock();
    t_pwm();
    t_status();
    t_otemp();
    t_ovv();
    t_freeze();
    t_rerun();
    finish_test();
  end
endmodule
